// file: rtl/poac_pkg.sv
// Purpose: constants and helpers of the port owner assignment block
// Assumes: byte wide configuration registers, 125 MHz core clock
// Notes:   owner codes are decoded here for reuse
package poac_pkg;
    localparam logic [7:0] ADDR_DELAY   = 8'hD0;
    localparam logic [7:0] ADDR_S0_P12  = 8'hD1;
    localparam logic [7:0] ADDR_S0_P34  = 8'hD2;
    localparam logic [7:0] ADDR_S0_RSVC = 8'hD3;
    localparam logic [7:0] ADDR_S0_RSVD = 8'hD4;
    localparam logic [7:0] ADDR_S1_P12  = 8'hD5;

    localparam logic [7:0] RESET_BYTE   = 8'h00;
    localparam logic [7:0] RSVD_BYTE    = 8'h00;

    localparam int LO_NIB_LSB = 0;
    localparam int HI_NIB_LSB = 4;

    localparam logic [3:0] CODE_NONE  = 4'h0;
    localparam logic [3:0] CODE_HOST1 = 4'h1;
    localparam logic [3:0] CODE_HOST2 = 4'h2;

    localparam logic [1:0] OWN_NONE   = 2'h0;
    localparam logic [1:0] OWN_HOST1  = 2'h1;
    localparam logic [1:0] OWN_HOST2  = 2'h2;

    localparam int CLK_PERIOD_NS = 8;
    localparam int DELAY_UNIT_NS = 1000000;
    localparam int CYCLES_PER_MS = DELAY_UNIT_NS / CLK_PERIOD_NS;

    function automatic logic [1:0] decode_owner(input logic [3:0] code);
        logic [1:0] own;
        own = OWN_HOST1;
        case (code)
            CODE_NONE:  own = OWN_NONE;
            CODE_HOST1: own = OWN_HOST1;
            CODE_HOST2: own = OWN_HOST2;
            default:    own = OWN_HOST1;
        endcase
        return own;
    endfunction : decode_owner
endpackage : poac_pkg

// file: rtl/poac_tmr_if.sv
// Purpose: carries the debounce timer request and its expiry
// Assumes: single clock domain
// Notes:   ctl side starts, tmr side counts
`timescale 1ns/100ps
interface poac_tmr_if;
    logic       start;
    logic [7:0] delay_ms;
    logic       done;

    modport ctl (output start, output delay_ms, input done);
    modport tmr (input start, input delay_ms, output done);
endinterface : poac_tmr_if

// file: rtl/poac_timer.sv
// Purpose: millisecond debounce timer, restartable
// Assumes: start is a one-cycle pulse from the same clock
// Notes:   a new start abandons any count in progress
`timescale 1ns/100ps
module poac_timer #(
    parameter int CYCLES_PER_MS = poac_pkg::CYCLES_PER_MS
) (
    input  wire logic clk,
    input  wire logic rst,
    poac_tmr_if.tmr   tif
);
    localparam int PW = $clog2(CYCLES_PER_MS + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(CYCLES_PER_MS - 1);

    typedef struct packed {
        logic [PW-1:0] pre;
        logic [7:0]    count;
        logic          run;
        logic          done;
    } poac_tmr_state_t;

    poac_tmr_state_t st;
    poac_tmr_state_t next_st;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st      = st;
        next_st.done = 1'b0;
        if (tif.start) begin
            next_st.pre   = '0;
            next_st.count = tif.delay_ms;
            next_st.run   = (tif.delay_ms != 8'h00);
            next_st.done  = (tif.delay_ms == 8'h00);
        end else if (st.run) begin
            if (st.pre == PRE_LAST) begin
                next_st.pre   = '0;
                next_st.count = st.count - 8'h01;
                if (st.count == 8'h01) begin
                    next_st.run  = 1'b0;
                    next_st.done = 1'b1;
                end
            end else begin
                next_st.pre = st.pre + PW'(1);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tif.done = st.done;
endmodule : poac_timer

// file: rtl/poac_top.sv
// Purpose: port owner assignment configuration and debounce
// Assumes: assignment pins are asynchronous to clk
// Notes:   byte register port, one register per address
//
// Behaviour
// - wait delay register milliseconds after pin change
// - on expiry move only affected ports
// - set0 byte1: port2 high, port1 low
// - set0 byte2: port4 high, port3 low
// - set1 byte1: same layout as set0
// - codes: zero none, one host1, two host2
// - codes three to fifteen mean host1
// - set0 reserved bytes always read zero
// - reset clears delay and all configuration
`timescale 1ns/100ps
module poac_top #(
    parameter int CYCLES_PER_MS = poac_pkg::CYCLES_PER_MS
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic [3:0] owner_select_pins,
    output logic      [7:0] port_owner,
    output logic      [3:0] port_switch_start
);
    typedef struct packed {
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] prev;
        logic [7:0] delay_ms;
        logic [7:0] s0_p12;
        logic [7:0] s0_p34;
        logic [7:0] s1_p12;
        logic [7:0] rdata;
        logic [7:0] owner;
        logic [3:0] sw_start;
        logic       start;
    } poac_state_t;

    poac_state_t st;
    poac_state_t next_st;
    poac_tmr_if  tif ();

    logic [7:0] sel_p12;
    logic [7:0] sel_p34;
    logic [7:0] new_owner;

    ////////////////////////////////////////////////////////////////////////
    // debounce timer
    poac_timer #(
        .CYCLES_PER_MS (CYCLES_PER_MS)
    ) u_timer (
        .clk (clk),
        .rst (rst),
        .tif (tif)
    );

    assign tif.start    = st.start;
    assign tif.delay_ms = st.delay_ms;

    ////////////////////////////////////////////////////////////////////////
    // owner selection from the settled pin state
    always_comb begin
        sel_p12 = st.s0_p12;
        sel_p34 = st.s0_p34;
        if (st.sync2 != 4'h0) begin
            sel_p12 = st.s1_p12;
        end
        new_owner[1:0] = poac_pkg::decode_owner(
            sel_p12[poac_pkg::LO_NIB_LSB +: 4]);
        new_owner[3:2] = poac_pkg::decode_owner(
            sel_p12[poac_pkg::HI_NIB_LSB +: 4]);
        new_owner[5:4] = poac_pkg::decode_owner(
            sel_p34[poac_pkg::LO_NIB_LSB +: 4]);
        new_owner[7:6] = poac_pkg::decode_owner(
            sel_p34[poac_pkg::HI_NIB_LSB +: 4]);
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_st          = st;
        next_st.sync1    = owner_select_pins;
        next_st.sync2    = st.sync1;
        next_st.prev     = st.sync2;
        next_st.start    = (st.sync2 != st.prev);
        next_st.sw_start = 4'h0;

        if (reg_wr) begin
            case (reg_addr)
                poac_pkg::ADDR_DELAY:  next_st.delay_ms = reg_wdata;
                poac_pkg::ADDR_S0_P12: next_st.s0_p12   = reg_wdata;
                poac_pkg::ADDR_S0_P34: next_st.s0_p34   = reg_wdata;
                poac_pkg::ADDR_S1_P12: next_st.s1_p12   = reg_wdata;
                default: begin
                end
            endcase
        end

        if (reg_rd) begin
            case (reg_addr)
                poac_pkg::ADDR_DELAY:   next_st.rdata = st.delay_ms;
                poac_pkg::ADDR_S0_P12:  next_st.rdata = st.s0_p12;
                poac_pkg::ADDR_S0_P34:  next_st.rdata = st.s0_p34;
                poac_pkg::ADDR_S0_RSVC: next_st.rdata = poac_pkg::RSVD_BYTE;
                poac_pkg::ADDR_S0_RSVD: next_st.rdata = poac_pkg::RSVD_BYTE;
                poac_pkg::ADDR_S1_P12:  next_st.rdata = st.s1_p12;
                default:                next_st.rdata = 8'h00;
            endcase
        end

        // a pin change in the expiry cycle restarts instead of applying
        if (tif.done && !st.start && (st.sync2 == st.prev)) begin
            next_st.owner  = new_owner;
            for (int i = 0; i < 4; i++) begin
                next_st.sw_start[i] =
                    (new_owner[2*i +: 2] != st.owner[2*i +: 2]);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st          <= '0;
            st.delay_ms <= poac_pkg::RESET_BYTE;
            st.s0_p12   <= poac_pkg::RESET_BYTE;
            st.s0_p34   <= poac_pkg::RESET_BYTE;
            st.s1_p12   <= poac_pkg::RESET_BYTE;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata         = st.rdata;
    assign port_owner        = st.owner;
    assign port_switch_start = st.sw_start;
endmodule : poac_top

// file: dv/poac_properties.sv
// Purpose: port owner block properties
// Assumes: sees top ports only
// Notes:   bound into poac_top
`timescale 1ns/100ps
module poac_properties #(
    parameter int CYCLES_PER_MS = 4
) (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [3:0] owner_select_pins,
    input wire logic [7:0] port_owner,
    input wire logic [3:0] port_switch_start
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_wr;
        reg_wr && reg_addr == poac_pkg::ADDR_S0_P12;
    endsequence
    sequence s_rd;
        reg_rd && reg_addr == poac_pkg::ADDR_S0_P12;
    endsequence
    AST_WR_RD: assert property (s_wr ##1 !reg_wr ##1 s_rd
        |=> reg_rdata == $past(reg_wdata, 3)) else $error("readback");
    AST_SW_PULSE: assert property (|port_switch_start
        |=> port_switch_start == 4'h0) else $error("long pulse");
    AST_SW_P1: assert property (port_switch_start[0] ==
        (port_owner[1:0] != $past(port_owner[1:0]))) else $error("p1");
    AST_SW_P2: assert property (port_switch_start[1] ==
        (port_owner[3:2] != $past(port_owner[3:2]))) else $error("p2");
    AST_SW_P3: assert property (port_switch_start[2] ==
        (port_owner[5:4] != $past(port_owner[5:4]))) else $error("p3");
    AST_SW_P4: assert property (port_switch_start[3] ==
        (port_owner[7:6] != $past(port_owner[7:6]))) else $error("p4");
    AST_OWN_CODE: assert property (
        ((port_owner >> 1) & port_owner & 8'h55) == 8'h00) else $error("code");
    AST_RD_RSVD: assert property (
        reg_rd && reg_addr inside {8'hD3, 8'hD4}
        |=> reg_rdata == 8'h00) else $error("reserved");
    AST_RD_UNMAP: assert property (reg_rd && reg_addr > 8'hD5
        |=> reg_rdata == 8'h00) else $error("unmapped");
    AST_RD_HOLD: assert property (!reg_rd
        |=> $stable(reg_rdata)) else $error("rdata moved");
    AST_RST_CLEAR: assert property ($fell(rst)
        |-> port_owner == 8'h00 && reg_rdata == 8'h00
        && port_switch_start == 4'h0) else $error("reset state");
endmodule : poac_properties
bind poac_top poac_properties #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_prop (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .owner_select_pins(owner_select_pins), .port_owner(port_owner),
    .port_switch_start(port_switch_start));

// file: dv/poac_switch_model.sv
// Purpose: bouncing mechanical switches on the assignment pins
// Assumes: changes on the falling clock edge
// Notes:   switches always drive, no float
`timescale 1ns/100ps
module poac_switch_model (
    input  wire logic       clk,
    output logic      [3:0] pins
);
    logic [3:0] last = 4'h0;
    initial pins = 4'h0;
    // n bounces of two g-cycle flips each, then settle on v
    task automatic flip(input logic [3:0] v, input int n, input int g);
        repeat (2 * n) begin
            @(negedge clk) pins = (pins == v) ? last : v;
            repeat (g - 1) @(negedge clk);
        end
        @(negedge clk) pins = v;
        last = v;
    endtask : flip
endmodule : poac_switch_model

// file: dv/test_poac_top.sv
// Purpose: register and switching tests of poac_top
// Assumes: one ms shortened to 4 cycles
// Notes:   inputs change on the falling edge
`timescale 1ns/100ps
module test_poac_top;
    logic       clk = 1'b0;
    logic       rst, reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, port_owner, q;
    logic [3:0] pins, port_switch_start;
    logic [7:0] wv [7] = '{8'hFF, 8'h31, 8'h20, 8'hAA, 8'h55, 8'h2F, 8'h77};
    logic [7:0] ev [7] = '{8'hFF, 8'h31, 8'h20, 8'h00, 8'h00, 8'h2F, 8'h00};
    int         miscompares = 0;
    int         cmp_count = 0;
    poac_top #(.CYCLES_PER_MS(4)) u_dut (.clk(clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .owner_select_pins(pins),
        .port_owner(port_owner), .port_switch_start(port_switch_start));
    poac_switch_model u_sw (.clk(clk), .pins(pins));
    initial forever #4 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string s, input logic [7:0] e, g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, d);
        @(negedge clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge clk) reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(negedge clk) {reg_rd, reg_addr} = {1'b1, a};
        @(negedge clk) reg_rd = 1'b0;
        q = reg_rdata;
    endtask : rd
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report
    // pins settle on v after n bounces; switch due m+4 to m+6 cycles later
    task automatic sw(input logic [3:0] v, input int n, m,
                      input logic [7:0] o, input logic [3:0] s);
        int k;
        u_sw.flip(v, n, 2);
        k = 0;
        while (port_switch_start === 4'h0 && k < 400) @(negedge clk) k++;
        if (k == 400) begin
            miscompares++;
            final_report();
        end
        check("delay_ok", 8'h01, {7'h00, k >= m + 4 && k <= m + 6});
        check("port_owner", o, port_owner);
        check("switch", {4'h0, s}, {4'h0, port_switch_start});
        $display("test pins %h done", v);
    endtask : sw
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 18'h0};
        repeat (20) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        for (int i = 0; i < 7; i++) begin
            rd(8'hD0 + 8'(i));
            check("reset", 8'h00, q);
        end
        $display("test reset done");
        for (int i = 0; i < 7; i++) begin
            wr(8'hD0 + 8'(i), wv[i]);
            rd(8'hD0 + 8'(i));
            check("readback", ev[i], q);
        end
        $display("test registers done");
        wr(8'hD0, 8'h03);
        sw(4'h1, 0, 12, 8'h89, 4'hB);
        sw(4'h0, 3, 12, 8'h85, 4'h2);
        wr(8'hD0, 8'h00);
        sw(4'h2, 0, 0, 8'h89, 4'h2);
        wr(8'hD2, 8'h12);
        sw(4'h0, 0, 0, 8'h65, 4'hE);
        final_report();
    end
endmodule : test_poac_top
